// file: smdc_defs.svh
// Constants for the system memory decode and control block.
// Assumes a 32-bit byte address bus and an 8-bit register port.
// How it works
// - ROM answers 000E0000-000FFFFF after reset
// - ROM also decoded at FFFE0000 top
// - ROM reads: no parity, four 50ns waits
// - RAM from zero, 32 data plus 4 parity
// - Write stores one parity bit per byte
// - Read checks one parity bit per byte
// - RAM enabled in aligned 1MB granules
// - Lowest megabyte never goes to channel
// - Reg1 bits 6,7 enable slot b megs
// - Reg1 bits 4,5 enable slot a megs
// - Reg2 bits 4,5 enable slot c megs
// - Reg1 bit 3 low enables split block
// - Top 128KB of first meg shadows ROM
// - Bit2 low: 640KB low, split 256KB
// - Bit2 high: 512KB low, split 384KB
// - ROM select high: reads ROM, writes RAM
// - ROM select low: reads RAM, writes dropped
// - Reg1 bit 0 low enables parity checking
// - Writing 1 then 0 clears parity error
// - Reg2 bits 3:0 give split start MB
`ifndef SMDC_DEFS_SVH
`define SMDC_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------
`define SMDC_OFS_REG2      16'h00E0
`define SMDC_OFS_REG1      16'h00E1
`define SMDC_REG1_RESET    8'hFE
`define SMDC_REG2_RESET    8'hFF
`define SMDC_REG2_RSV_MASK 8'hC0
`define SMDC_B_PAR_OFF_N   0
`define SMDC_B_ROM_SEL     1
`define SMDC_B_SPLIT512    2
`define SMDC_B_SPLIT_OFF_N 3

// ----------------------------------------------------------------
// Address map
// ----------------------------------------------------------------
`define SMDC_ROM_LO_BASE   32'h000E0000
`define SMDC_ROM_HI_BASE   32'hFFFE0000
`define SMDC_ROM_SIZE      32'h00020000
`define SMDC_LOW640_END    32'h000A0000
`define SMDC_LOW512_END    32'h00080000
`define SMDC_MEG_BYTES     32'h00100000
`define SMDC_SPLIT640_SIZE 32'h00040000
`define SMDC_SPLIT512_SIZE 32'h00060000
`define SMDC_SPLIT640_OFS  32'h000A0000
`define SMDC_SPLIT512_OFS  32'h00080000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SMDC_CLK_NS        5
`define SMDC_WAIT_NS       50
`define SMDC_ROM_WAITS     4
`define SMDC_ROM_CYC       ((`SMDC_ROM_WAITS * `SMDC_WAIT_NS + `SMDC_CLK_NS - 1) / `SMDC_CLK_NS)

`endif

// file: smdc_pkg.sv
// Types for the system memory decode and control block.
// Assumes smdc_defs.svh supplies every number.
package smdc_pkg;

   // Decoded target of one access
   typedef enum logic [2:0]
   {
      SMDC_TGT_NONE = 3'h0,
      SMDC_TGT_ROM  = 3'h1,
      SMDC_TGT_RAM  = 3'h2,
      SMDC_TGT_CHAN = 3'h3
   } smdc_target_t;

   // Master request
   typedef struct packed
   {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [3:0]  byte_en;
      logic [31:0] wdata;
   } smdc_req_t;

   // RAM side: 32 data plus 4 parity bits
   typedef struct packed
   {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [3:0]  byte_en;
      logic [31:0] data;
      logic [3:0]  parity;
   } smdc_ram_cmd_t;

   typedef struct packed
   {
      logic [31:0] data;
      logic [3:0]  parity;
   } smdc_ram_word_t;

endpackage

// file: smdc_decode.sv
// Memory decoder with encoding registers, ROM wait timing and parity.
// Assumes one master request at a time; RAM read data returns the
// cycle after the request; ROM data is held by the ROM while selected.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "smdc_defs.svh"

module smdc_decode
   import smdc_pkg::*;
#(
   parameter int NUM_SLOTS = 3
)
(
   // Clock, reset, enable
   input  wire logic           mclk_i,
   input  wire logic           srst_i,
   input  wire logic           ce_i,
   // Register port
   input  wire logic [15:0]    reg_addr_i,
   input  wire logic [7:0]     reg_wdata_i,
   input  wire logic           reg_wr_i,
   input  wire logic           reg_rd_i,
   output logic      [7:0]     reg_rdata_o,
   // Master access
   input  wire smdc_req_t      req_i,
   output logic                ready_o,
   output logic      [31:0]    rdata_o,
   output smdc_target_t        target_o,
   // ROM and RAM sides
   output logic                rom_sel_o,
   input  wire logic [31:0]    rom_data_i,
   output smdc_ram_cmd_t       ram_cmd_o,
   input  wire smdc_ram_word_t ram_rdata_i,
   // Parity status
   output logic                parity_err_o
);

   // ----------------------------------------------------------------
   // Encoding registers
   // ----------------------------------------------------------------
   logic [7:0] reg1_reg;
   logic [7:0] reg2_reg;
   logic       par_err_reg;
   logic       clr_armed_reg;

   wire hit1 = (reg_addr_i == `SMDC_OFS_REG1);
   wire hit2 = (reg_addr_i == `SMDC_OFS_REG2);

   wire [7:0] reg2_wval = reg_wdata_i | `SMDC_REG2_RSV_MASK;

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         reg1_reg <= `SMDC_REG1_RESET;
         reg2_reg <= `SMDC_REG2_RESET;
      end
      else if (ce_i && reg_wr_i)
      begin
         if (hit1)
            reg1_reg <= reg_wdata_i;
         if (hit2)
            reg2_reg <= reg2_wval;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
         reg_rdata_o <= 8'h00;
      else if (ce_i)
         reg_rdata_o <= !reg_rd_i ? 8'h00 : hit1 ? reg1_reg : hit2 ? reg2_reg : 8'h00;
   end

   wire       par_off_n   = reg1_reg[`SMDC_B_PAR_OFF_N];
   wire       rom_read_select = reg1_reg[`SMDC_B_ROM_SEL];
   wire       split512    = reg1_reg[`SMDC_B_SPLIT512];
   wire       split_block_off_n = reg1_reg[`SMDC_B_SPLIT_OFF_N];
   wire [3:0] split_start = reg2_reg[3:0];

   // ----------------------------------------------------------------
   // Installed megabyte granules
   // ----------------------------------------------------------------
   // active-low granule enables, two per slot
   wire [2*NUM_SLOTS-1:0] meg_on_n = {reg2_reg[5:4], reg1_reg[7:6], reg1_reg[5:4]};
   logic [2*NUM_SLOTS-1:0] meg_on;
   logic [4:0]             meg_count [0:2*NUM_SLOTS];

   assign meg_count[0] = 5'h00;
   genvar g;
   generate
      for (g = 0; g < 2*NUM_SLOTS; g = g + 1)
      begin : g_meg
         assign meg_on[g]      = ~meg_on_n[g];
         assign meg_count[g+1] = meg_count[g] + {4'h0, meg_on[g]};
      end
   endgenerate

   // First active meg is physical meg 0; the rest sit at 1MB upward.
   // granule count checked against whole-meg address bits
   wire [4:0] total_megs = meg_count[2*NUM_SLOTS];
   wire [4:0] ext_megs   = (total_megs == 5'h00) ? 5'h00 : total_megs - 5'h01;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   wire [31:0] a      = req_i.addr;
   wire        wr     = req_i.write;
   wire [11:0] a_meg  = a[31:20];
   wire        in_rom_lo = (a >= `SMDC_ROM_LO_BASE) && (a < `SMDC_ROM_LO_BASE + `SMDC_ROM_SIZE);
   wire        in_rom_hi = (a >= `SMDC_ROM_HI_BASE);
   wire [31:0] low_end   = split512 ? `SMDC_LOW512_END : `SMDC_LOW640_END;
   wire        in_low    = (a < low_end);
   wire        in_ext    = (a_meg != 12'h000) && ({5'h00, a_meg} <= {12'h000, ext_megs}) && (ext_megs != 5'h00);
   wire [31:0] split_base = {8'h00, split_start, 20'h00000};
   wire [31:0] split_size = split512 ? `SMDC_SPLIT512_SIZE : `SMDC_SPLIT640_SIZE;
   wire        split_on   = !split_block_off_n && (split_start != 4'h0);
   wire        in_split   = split_on && (a >= split_base) && (a < split_base + split_size);
   wire [31:0] split_phys = (a - split_base) + (split512 ? `SMDC_SPLIT512_OFS : `SMDC_SPLIT640_OFS);
   // shadow is top 128KB of first active meg
   wire        shadow_ok  = (total_megs != 5'h00);
   wire        rom_hit    = in_rom_hi || (in_rom_lo && !wr && rom_read_select);
   wire        shadow_hit = in_rom_lo && shadow_ok && (wr ? rom_read_select : !rom_read_select);
   wire        ram_hit    = shadow_ok && (in_low || in_ext || in_split || shadow_hit);
   // lowest meg never handed to the channel
   wire        chan_hit   = (a_meg != 12'h000) && !ram_hit && !rom_hit;

   smdc_target_t tgt;
   assign tgt = rom_hit ? SMDC_TGT_ROM : ram_hit ? SMDC_TGT_RAM : chan_hit ? SMDC_TGT_CHAN : SMDC_TGT_NONE;
   wire [31:0] ram_addr = in_split ? split_phys : a;

   // ----------------------------------------------------------------
   // Access sequencing
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_ROM  = 3'b010,
      ST_RAMR = 3'b100
   } smdc_state_t;

   smdc_state_t st_reg;
   smdc_state_t st_next;
   logic [7:0]  wait_reg;
   logic [3:0]  rd_be_reg;

   wire start = (st_reg == ST_IDLE) && req_i.valid;

   always_comb
   begin
      st_next = st_reg;
      unique case (st_reg)
         ST_IDLE: if (req_i.valid && tgt == SMDC_TGT_ROM && !wr)
                     st_next = ST_ROM;
                  else if (req_i.valid && tgt == SMDC_TGT_RAM && !wr)
                     st_next = ST_RAMR;
         ST_ROM:  if (wait_reg == 8'h00)
                     st_next = ST_IDLE;
         ST_RAMR: st_next = ST_IDLE;
      endcase
   end

   // four 50ns wait states on ROM reads
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         st_reg    <= ST_IDLE;
         wait_reg  <= 8'h00;
         rd_be_reg <= 4'h0;
      end
      else if (ce_i)
      begin
         st_reg    <= st_next;
         wait_reg  <= start ? 8'(`SMDC_ROM_CYC - 1) : (wait_reg != 8'h00 ? wait_reg - 8'h01 : 8'h00);
         rd_be_reg <= start ? req_i.byte_en : rd_be_reg;
      end
   end

   // ROM ignores writes, so only ROM reads pay the wait states
   assign ready_o   = (st_reg == ST_IDLE && req_i.valid && !(tgt == SMDC_TGT_ROM && !wr) && !(tgt == SMDC_TGT_RAM && !wr))
                    || (st_reg == ST_ROM && wait_reg == 8'h00) || (st_reg == ST_RAMR);
   assign rom_sel_o = (st_reg == ST_ROM);

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         rdata_o  <= 32'h00000000;
         target_o <= SMDC_TGT_NONE;
      end
      else if (ce_i)
      begin
         if (start)
            target_o <= tgt;
         if (st_reg == ST_ROM && wait_reg == 8'h01)
            rdata_o <= rom_data_i;
         else if (start && tgt == SMDC_TGT_RAM && !wr)
            rdata_o <= 32'h00000000;
      end
   end

   // ----------------------------------------------------------------
   // Parity generation and check
   // ----------------------------------------------------------------
   logic [3:0] wpar;
   logic [3:0] rbad;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_par
         assign wpar[g] = ~^req_i.wdata[8*g +: 8];
         // per-byte check of bytes actually read
         assign rbad[g] = rd_be_reg[g] && ((~^ram_rdata_i.data[8*g +: 8]) != ram_rdata_i.parity[g]);
      end
   endgenerate

   always_comb
   begin
      ram_cmd_o         = '0;
      ram_cmd_o.valid   = start && (tgt == SMDC_TGT_RAM) && ce_i;
      ram_cmd_o.write   = wr;
      ram_cmd_o.addr    = ram_addr;
      ram_cmd_o.byte_en = req_i.byte_en;
      ram_cmd_o.data    = req_i.wdata;
      ram_cmd_o.parity  = wpar;
   end

   // RAM read data does not reach rdata_o, which is cleared when a RAM read starts; the check runs alongside

   // check only while enable bit is low
   wire par_event = (st_reg == ST_RAMR) && !par_off_n && (rbad != 4'h0);
   // arm on 1, clear on following 0
   wire par_clr   = ce_i && reg_wr_i && hit1 && clr_armed_reg && !reg_wdata_i[`SMDC_B_PAR_OFF_N];

   // sticky error; a new mismatch wins over the clear
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         par_err_reg   <= 1'b0;
         // Not armed until software has written a one
         clr_armed_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         par_err_reg <= par_event ? 1'b1 : (par_clr ? 1'b0 : par_err_reg);
         if (reg_wr_i && hit1)
            clr_armed_reg <= reg_wdata_i[`SMDC_B_PAR_OFF_N];
      end
   end

   assign parity_err_o = par_err_reg;

endmodule

// file: smdc_decode_properties.sv
// Port checker for the memory decoder.
// Assumes ce_i stays high and one master request at a time.
`timescale 1ns/1ps
`include "smdc_defs.svh"
module smdc_decode_properties
   import smdc_pkg::*;
(
   // Clock and reset
   input wire logic          mclk_i,
   input wire logic          srst_i,
   // Watched ports
   input wire logic [15:0]   reg_addr_i,
   input wire logic          reg_rd_i,
   input wire logic          reg_wr_i,
   input wire logic [7:0]    reg_rdata_o,
   input wire smdc_req_t     req_i,
   input wire logic          ready_o,
   input wire smdc_target_t  target_o,
   input wire logic          rom_sel_o,
   input wire smdc_ram_cmd_t ram_cmd_o,
   input wire logic          parity_err_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   a_rom_wait: assert property ($rose(rom_sel_o) |-> (!ready_o) [*8] ##32 ready_o)
      else $error("ROM read too short or hung");
   a_rom_read: assert property (rom_sel_o |-> req_i.valid && !req_i.write)
      else $error("ROM selected outside a read");
   // Each byte together with its parity bit holds an odd count of ones
   a_wr_parity: assert property (ram_cmd_o.valid && ram_cmd_o.write |->
                                 ^{ram_cmd_o.data[7:0], ram_cmd_o.parity[0]}
                                 && ^{ram_cmd_o.data[15:8], ram_cmd_o.parity[1]}
                                 && ^{ram_cmd_o.data[23:16], ram_cmd_o.parity[2]}
                                 && ^{ram_cmd_o.data[31:24], ram_cmd_o.parity[3]})
      else $error("bad write parity");
   a_ram_answer: assert property (ram_cmd_o.valid && !ram_cmd_o.write |=> ready_o)
      else $error("RAM read not done next cycle");
   a_low_meg: assert property (req_i.valid && ready_o && req_i.addr[31:20] == 12'h000
                               |=> target_o != SMDC_TGT_CHAN)
      else $error("low meg sent to channel");
   a_rsv_ones: assert property (reg_rd_i && reg_addr_i == `SMDC_OFS_REG2 |=> reg_rdata_o[7:6] == 2'h3)
      else $error("reserved bits not one");
   a_err_hold: assert property (parity_err_o && !reg_wr_i |=> parity_err_o)
      else $error("parity error dropped");
   a_err_cause: assert property ($rose(parity_err_o) |-> $past(ready_o))
      else $error("parity error without a read");
endmodule
bind smdc_decode smdc_decode_properties u_props (.mclk_i, .srst_i, .reg_addr_i, .reg_rd_i, .reg_wr_i,
   .reg_rdata_o, .req_i, .ready_o, .target_o, .rom_sel_o, .ram_cmd_o, .parity_err_o);

// file: smdc_mem_model.sv
// RAM with parity and a ROM word behind the decoder.
// Assumes one-cycle commands; only 16 word slots are kept.
`timescale 1ns/1ps
module smdc_mem_model
   import smdc_pkg::*;
#(
   parameter logic [31:0] ROM_WORD = 32'h5A3C96E1
)
(
   // Clock and fault control
   input  wire logic           mclk_i,
   input  wire logic           flip_i,
   // Decoder side
   input  wire smdc_ram_cmd_t  cmd_i,
   input  wire logic           rom_sel_i,
   output smdc_ram_word_t      word_o = '0,
   output logic      [31:0]    rom_data_o
);
   smdc_ram_word_t mem [16];
   // Idle pins carry inverted data so stale data never passes
   assign rom_data_o = rom_sel_i ? ROM_WORD : ~ROM_WORD;
   always @(posedge mclk_i)
   begin
      // stored parity returned, flipped on demand
      if (cmd_i.valid && !cmd_i.write)
         word_o <= mem[cmd_i.addr[5:2]] ^ {35'h0, flip_i};
      else
         word_o <= ~word_o;
      if (cmd_i.valid && cmd_i.write)
         mem[cmd_i.addr[5:2]] <= {cmd_i.data, cmd_i.parity};
   end
endmodule

// file: test_system_memory_decode_control.sv
// Self-checking bench for smdc_decode with a memory model.
// Assumes ce_i held high and one request at a time.
`timescale 1ns/1ps
`include "smdc_defs.svh"
module test_system_memory_decode_control;
   import smdc_pkg::*;
   logic           mclk_i = 0, srst_i = 1, reg_wr_i = 0, reg_rd_i = 0, flip = 0;
   logic [15:0]    reg_addr_i = '0;
   logic [7:0]     reg_wdata_i = '0, reg_rdata_o;
   smdc_req_t      req_i = '0;
   logic           ready_o, rom_sel_o, parity_err_o;
   logic [31:0]    rdata_o, rom_data, got;
   smdc_target_t   target_o;
   smdc_ram_cmd_t  ram_cmd_o;
   smdc_ram_word_t ram_word;
   int             mismatches = 0, samples_checked = 0, n;
   smdc_decode u_dut (.mclk_i, .srst_i, .ce_i(1'h1), .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .req_i, .ready_o, .rdata_o, .target_o, .rom_sel_o, .rom_data_i(rom_data),
      .ram_cmd_o, .ram_rdata_i(ram_word), .parity_err_o);
   smdc_mem_model u_mem (.mclk_i, .flip_i(flip), .cmd_i(ram_cmd_o), .rom_sel_i(rom_sel_o),
      .word_o(ram_word), .rom_data_o(rom_data));
   initial
   begin
      forever #2.5 mclk_i = ~mclk_i;
   end
   task automatic cmp(input logic [31:0] g, e);
      samples_checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wreg(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'h1;
      @(posedge mclk_i);
      reg_wr_i    <= 1'h0;
   endtask
   task automatic rchk(input logic [15:0] a, input logic [7:0] e);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'h1;
      @(posedge mclk_i);
      reg_rd_i   <= 1'h0;
      #1 cmp({24'h0, reg_rdata_o}, {24'h0, e});
   endtask
   // Program both registers, then one master access held until ready
   task automatic go(input logic [7:0] r1, r2, input logic w, input logic [31:0] a,
                     input smdc_target_t et, input logic [31:0] d = 32'h0, ed = 32'h0);
      wreg(`SMDC_OFS_REG1, r1);
      wreg(`SMDC_OFS_REG2, r2);
      @(posedge mclk_i);
      req_i <= '{1'h1, w, a, 4'hF, d};
      n = 0;
      #1;
      while (!ready_o && n < 60)
      begin
         @(posedge mclk_i);
         #1 n++;
      end
      got = rom_sel_o ? rdata_o : ram_word.data;
      @(posedge mclk_i);
      req_i.valid <= 1'h0;
      #1 cmp(32'(target_o), 32'(et));
      if (!w)
         cmp(got, ed);
   endtask
   task automatic end_of_test();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      #100000;
      mismatches++;
      end_of_test();
   end
   initial
   begin
      repeat (2) @(posedge mclk_i);
      srst_i <= 1'h0;
      rchk(`SMDC_OFS_REG1, `SMDC_REG1_RESET);
      rchk(`SMDC_OFS_REG2, `SMDC_REG2_RESET);
      rchk(16'h0010, 8'h00);
      go(8'hFE, 8'hFF, 1'h0, 32'h000E0000, SMDC_TGT_ROM, 32'h0, u_mem.ROM_WORD);
      cmp(32'(n), `SMDC_ROM_CYC);
      go(8'hFE, 8'hFF, 1'h0, 32'hFFFE0004, SMDC_TGT_ROM, 32'h0, u_mem.ROM_WORD);
      wreg(`SMDC_OFS_REG2, 8'h01);
      rchk(`SMDC_OFS_REG2, 8'hC1);
      go(8'hEA, 8'hFF, 1'h1, 32'h00090000, SMDC_TGT_RAM);
      go(8'hEE, 8'hFF, 1'h1, 32'h00090000, SMDC_TGT_NONE);
      go(8'hEE, 8'hFF, 1'h1, 32'h0007FFFC, SMDC_TGT_RAM);
      go(8'hEA, 8'hFF, 1'h1, 32'h00100000, SMDC_TGT_CHAN);
      go(8'hCA, 8'hFF, 1'h1, 32'h00100000, SMDC_TGT_RAM);
      go(8'hBA, 8'hFF, 1'h1, 32'h00000000, SMDC_TGT_RAM);
      go(8'h7A, 8'hFF, 1'h1, 32'h00000000, SMDC_TGT_RAM);
      go(8'hEA, 8'hEF, 1'h1, 32'h00100000, SMDC_TGT_RAM);
      go(8'hEA, 8'hDF, 1'h1, 32'h00100000, SMDC_TGT_RAM);
      // split placed at 2MB with only 1MB installed, far below 16MB
      go(8'hE2, 8'hF2, 1'h1, 32'h0023FFFC, SMDC_TGT_RAM);
      go(8'hE6, 8'hF2, 1'h1, 32'h0025FFFC, SMDC_TGT_RAM);
      go(8'hEA, 8'hF2, 1'h1, 32'h00200000, SMDC_TGT_CHAN);
      go(8'hEA, 8'hFF, 1'h1, 32'h000E0000, SMDC_TGT_RAM, 32'hA5C30F81);
      go(8'hE8, 8'hFF, 1'h1, 32'h000E0000, SMDC_TGT_NONE, 32'h3C3C3C3C);
      go(8'hE8, 8'hFF, 1'h0, 32'h000E0000, SMDC_TGT_RAM, 32'h0, 32'hA5C30F81);
      go(8'hEA, 8'hFF, 1'h1, 32'h00000004, SMDC_TGT_RAM, 32'h8001FE7F);
      flip = 1'h1;
      go(8'hEB, 8'hFF, 1'h0, 32'h00000004, SMDC_TGT_RAM, 32'h0, 32'h8001FE7F);
      cmp({31'h0, parity_err_o}, 32'h0);
      go(8'hEA, 8'hFF, 1'h0, 32'h00000004, SMDC_TGT_RAM, 32'h0, 32'h8001FE7F);
      cmp({31'h0, parity_err_o}, 32'h1);
      flip = 1'h0;
      wreg(`SMDC_OFS_REG1, 8'hEA);
      #1 cmp({31'h0, parity_err_o}, 32'h1);
      wreg(`SMDC_OFS_REG1, 8'hEB);
      #1 cmp({31'h0, parity_err_o}, 32'h1);
      wreg(`SMDC_OFS_REG1, 8'hEA);
      @(posedge mclk_i);
      #1 cmp({31'h0, parity_err_o}, 32'h0);
      end_of_test();
   end
endmodule
